// file: design/lthm_pkg.sv
// Package of offsets, fields, reset values and timing for the load threshold monitor
package lthm_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] LTHM_OFS_CTRL     = 8'h00;
    localparam logic [7:0] LTHM_OFS_RATED    = 8'h04;
    localparam logic [7:0] LTHM_OFS_LOW_PCT  = 8'h08;
    localparam logic [7:0] LTHM_OFS_LOW_DLY  = 8'h0c;
    localparam logic [7:0] LTHM_OFS_HIGH_PCT = 8'h10;
    localparam logic [7:0] LTHM_OFS_HIGH_DLY = 8'h14;
    localparam logic [7:0] LTHM_OFS_STAB_DLY = 8'h18;
    localparam logic [7:0] LTHM_OFS_STATUS   = 8'h1c;
    localparam logic [7:0] LTHM_OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] LTHM_OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] LTHM_OFS_POWER    = 8'h28;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LTHM_CTRL_DIR     = 0;  // 0 low power, 1 high power
    localparam int LTHM_CTRL_ASSIGN  = 1;  // Alarm output function assigned
    localparam int LTHM_CTRL_EN_CFG  = 2;  // Enable input configured
    localparam int LTHM_ST_ALARM     = 0;
    localparam int LTHM_ST_ACTIVE    = 1;
    localparam int LTHM_ST_STAB      = 2;
    localparam int LTHM_ST_BADCFG    = 3;
    localparam int LTHM_ST_BELOW     = 4;
    localparam int LTHM_ST_ABOVE     = 5;
    localparam int LTHM_IRQ_SET      = 0;  // Alarm output went high
    localparam int LTHM_IRQ_CLR      = 1;  // Alarm output went low

    // ------------------------------------------------------------------
    // Reset values and direction codes
    // ------------------------------------------------------------------
    localparam logic       LTHM_DIR_LOW   = 1'b0;
    localparam logic       LTHM_DIR_HIGH  = 1'b1;
    localparam logic [2:0] LTHM_CTRL_RST  = 3'h0;
    localparam logic [7:0] LTHM_PCT_RST   = 8'h00;
    localparam logic [15:0] LTHM_RATED_RST = 16'h0064;
    localparam logic [15:0] LTHM_DLY_RST   = 16'h0000;
    localparam logic [6:0] LTHM_PCT_SCALE = 7'h64;  // Percent divisor, 100

    // ------------------------------------------------------------------
    // Timing: one second base at the system clock rate
    // ------------------------------------------------------------------
    localparam int LTHM_CLK_PERIOD_NS = 100;
    localparam int LTHM_SECOND_NS     = 1000000000;
    localparam int LTHM_TICK_CYCLES   = LTHM_SECOND_NS / LTHM_CLK_PERIOD_NS;
endpackage : lthm_pkg

// file: design/lthm_qual.sv
// Qualification timer: counts whole seconds while a condition holds
`timescale 1ns/1ps
module lthm_qual #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Seconds base and condition
    input  wire logic         tick,
    input  wire logic         cond,
    input  wire logic [W-1:0] dly,
    // Result
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } lthm_qual_t;

    lthm_qual_t s_q;
    lthm_qual_t s_d;

    // Condition met long enough; a zero delay qualifies at once
    assign done = cond && (s_q.cnt >= dly);

    // Count restarts from zero whenever the condition drops
    always_comb begin
        s_d = s_q;
        if (!cond) begin
            s_d.cnt = '0;
        end else if (tick && !done) begin
            s_d.cnt = s_q.cnt + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_QUAL_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
        !cond |=> (s_q.cnt == '0))
        else $error("qualifier count not cleared after condition loss");
    AST_QUAL_SECONDS: assert property (@(posedge clk) disable iff (!rst_n)
        (cond && !tick && !done) ##1 cond |-> (s_q.cnt == $past(s_q.cnt)))
        else $error("qualifier advanced without a seconds tick");
endmodule : lthm_qual

// file: design/lthm_top.sv
// Load threshold monitor with AHB-Lite register slave and interrupt
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
import lthm_pkg::*;

module lthm_top
    import lthm_pkg::*;
#(
    parameter int PW          = 16,
    parameter int TICK_CYCLES = LTHM_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic          CLK_SYS,
    input  wire logic          RST_N,
    // AHB-Lite slave
    input  wire logic          HSEL,
    input  wire logic [31:0]   HADDR,
    input  wire logic [1:0]    HTRANS,
    input  wire logic          HWRITE,
    input  wire logic [2:0]    HSIZE,
    input  wire logic [31:0]   HWDATA,
    input  wire logic          HREADY,
    output logic [31:0]        HRDATA,
    output logic               HREADYOUT,
    output logic               HRESP,
    // Measurement and control pins
    input  wire logic [PW-1:0] POWER_TOTAL,
    input  wire logic          THRESHOLD_ENABLE_INPUT,
    output logic               THRESHOLD_ALARM_OUTPUT,
    // Interrupt
    output logic               IRQ
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]    ctrl;
        logic [PW-1:0] rated;
        logic [7:0]    low_pct;
        logic [15:0]   low_dly;
        logic [7:0]    high_pct;
        logic [15:0]   high_dly;
        logic [15:0]   stab_dly;
        logic [1:0]    irq_st;
        logic [1:0]    irq_mask;
        logic          alarm;
        logic [23:0]   tick_cnt;
        logic          tick;
        logic          dph_wr;
        logic [7:0]    dph_addr;
        logic [31:0]   rdata;
    } lthm_state_t;

    // Registers, seconds divider and bus data-phase capture share one state word
    lthm_state_t s_q;
    lthm_state_t s_d;

    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
    localparam int          MW        = PW + 8;

    // ------------------------------------------------------------------
    // Threshold comparison
    // ------------------------------------------------------------------
    logic [MW-1:0] pwr_scaled;
    logic [MW-1:0] low_lim;
    logic [MW-1:0] high_lim;
    logic          below_low;
    logic          above_high;
    logic          cfg_ok;
    logic          enabled;
    logic          stab;
    logic          active;
    logic [2:0]    q_cond;
    logic [2:0]    q_done;
    logic [15:0]   q_dly [3];

    // Scale power by 100 rather than dividing the limits: no rounding loss
    assign pwr_scaled = MW'(POWER_TOTAL) * MW'(LTHM_PCT_SCALE);
    assign low_lim    = MW'(s_q.low_pct) * MW'(s_q.rated);
    assign high_lim   = MW'(s_q.high_pct) * MW'(s_q.rated);
    assign below_low  = pwr_scaled < low_lim;
    assign above_high = pwr_scaled > high_lim;

    // Zero pair or low not strictly below high leaves the function off
    assign cfg_ok = (s_q.low_pct != LTHM_PCT_RST || s_q.high_pct != LTHM_PCT_RST)
                    && (s_q.low_pct < s_q.high_pct);

    // Without a configured enable input the monitor is always enabled
    assign enabled = !s_q.ctrl[LTHM_CTRL_EN_CFG] || THRESHOLD_ENABLE_INPUT;

    // Stabilisation runs from the enable rise until its delay elapses
    assign stab   = enabled && !q_done[2];
    assign active = cfg_ok && enabled && !stab && s_q.ctrl[LTHM_CTRL_ASSIGN];

    // ------------------------------------------------------------------
    // Qualification timers: below-low, above-high, stabilisation
    // ------------------------------------------------------------------
    // Limitation: the tick runs free, so n seconds qualify after n-1 to n seconds
    // Each timer sees its own condition; leaving the region clears it at once
    assign q_cond[0] = active && below_low;
    assign q_cond[1] = active && above_high;
    assign q_cond[2] = enabled;
    assign q_dly[0]  = s_q.low_dly;
    assign q_dly[1]  = s_q.high_dly;
    assign q_dly[2]  = s_q.stab_dly;

    for (genvar i = 0; i < 3; i++) begin : g_qual
        lthm_qual #(
            .W (16)
        ) u_qual (
            .clk   (CLK_SYS),
            .rst_n (RST_N),
            .tick  (s_q.tick),
            .cond  (q_cond[i]),
            .dly   (q_dly[i]),
            .done  (q_done[i])
        );
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic       aph_valid;
    logic       dph_wr_hit;
    logic [1:0] ev;
    logic [31:0] rd_mux;
    logic [31:0] status;

    // Only the low address byte is decoded, so the map aliases every 256 bytes
    assign aph_valid  = HSEL && HTRANS[1] && HREADY;
    assign dph_wr_hit = s_q.dph_wr;

    // Status view of the block's own state
    assign status = {26'h0, above_high, below_low, !cfg_ok, stab && cfg_ok,
                     active, s_q.alarm};

    // Read multiplexer, sampled in the address phase
    // Trade-off: a read right after a write to one register still sees the old value
    always_comb begin
        rd_mux = 32'h0;
        if (HADDR[7:0] == LTHM_OFS_CTRL) begin
            rd_mux = {29'h0, s_q.ctrl};
        end else if (HADDR[7:0] == LTHM_OFS_RATED) begin
            rd_mux = 32'(s_q.rated);
        end else if (HADDR[7:0] == LTHM_OFS_LOW_PCT) begin
            rd_mux = {24'h0, s_q.low_pct};
        end else if (HADDR[7:0] == LTHM_OFS_LOW_DLY) begin
            rd_mux = {16'h0, s_q.low_dly};
        end else if (HADDR[7:0] == LTHM_OFS_HIGH_PCT) begin
            rd_mux = {24'h0, s_q.high_pct};
        end else if (HADDR[7:0] == LTHM_OFS_HIGH_DLY) begin
            rd_mux = {16'h0, s_q.high_dly};
        end else if (HADDR[7:0] == LTHM_OFS_STAB_DLY) begin
            rd_mux = {16'h0, s_q.stab_dly};
        end else if (HADDR[7:0] == LTHM_OFS_STATUS) begin
            rd_mux = status;
        end else if (HADDR[7:0] == LTHM_OFS_IRQ_STAT) begin
            rd_mux = {30'h0, s_q.irq_st};
        end else if (HADDR[7:0] == LTHM_OFS_IRQ_MASK) begin
            rd_mux = {30'h0, s_q.irq_mask};
        end else if (HADDR[7:0] == LTHM_OFS_POWER) begin
            rd_mux = 32'(POWER_TOTAL);
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // Seconds base: one-cycle pulse every TICK_CYCLES cycles
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == TICK_LAST) begin
            s_d.tick_cnt = 24'h0;
            s_d.tick     = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 24'h1;
        end

        // Alarm: held low whenever the monitor is not active
        if (!active) begin
            s_d.alarm = 1'b0;
        end else if (s_q.ctrl[LTHM_CTRL_DIR] == LTHM_DIR_LOW) begin
            if (q_done[0]) begin
                s_d.alarm = 1'b1;
            end else if (q_done[1]) begin
                s_d.alarm = 1'b0;
            end
        end else begin
            if (q_done[1]) begin
                s_d.alarm = 1'b1;
            end else if (q_done[0]) begin
                s_d.alarm = 1'b0;
            end
        end

        // Register write in the data phase
        if (dph_wr_hit) begin
            if (s_q.dph_addr == LTHM_OFS_CTRL) begin
                s_d.ctrl = HWDATA[2:0];
            end else if (s_q.dph_addr == LTHM_OFS_RATED) begin
                s_d.rated = HWDATA[PW-1:0];
            end else if (s_q.dph_addr == LTHM_OFS_LOW_PCT) begin
                s_d.low_pct = HWDATA[7:0];
            end else if (s_q.dph_addr == LTHM_OFS_LOW_DLY) begin
                s_d.low_dly = HWDATA[15:0];
            end else if (s_q.dph_addr == LTHM_OFS_HIGH_PCT) begin
                s_d.high_pct = HWDATA[7:0];
            end else if (s_q.dph_addr == LTHM_OFS_HIGH_DLY) begin
                s_d.high_dly = HWDATA[15:0];
            end else if (s_q.dph_addr == LTHM_OFS_STAB_DLY) begin
                s_d.stab_dly = HWDATA[15:0];
            end else if (s_q.dph_addr == LTHM_OFS_IRQ_STAT) begin
                s_d.irq_st = s_q.irq_st & ~HWDATA[1:0];
            end else if (s_q.dph_addr == LTHM_OFS_IRQ_MASK) begin
                s_d.irq_mask = HWDATA[1:0];
            end
        end

        // Alarm edges, taken from the next value so the status sets with the pin
        ev[LTHM_IRQ_SET] = s_d.alarm && !s_q.alarm;
        ev[LTHM_IRQ_CLR] = !s_d.alarm && s_q.alarm;

        // Events set after the clear so a same-cycle event is kept
        s_d.irq_st = s_d.irq_st | ev;

        // Address phase capture; zero wait, read data from a flop
        s_d.dph_wr   = aph_valid && HWRITE;
        s_d.dph_addr = HADDR[7:0];
        if (aph_valid && !HWRITE) begin
            s_d.rdata = rd_mux;
        end
    end

    // State register; defaults give a low-direction, zero-threshold monitor
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s_q          <= '0;
            s_q.ctrl     <= LTHM_CTRL_RST;
            s_q.rated    <= PW'(LTHM_RATED_RST);
            s_q.low_pct  <= LTHM_PCT_RST;
            s_q.high_pct <= LTHM_PCT_RST;
            s_q.low_dly  <= LTHM_DLY_RST;
            s_q.high_dly <= LTHM_DLY_RST;
            s_q.stab_dly <= LTHM_DLY_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Alarm and read data come straight from flops; the interrupt is a level
    assign THRESHOLD_ALARM_OUTPUT = s_q.alarm;
    assign IRQ       = |(s_q.irq_st & s_q.irq_mask);
    assign HRDATA    = s_q.rdata;
    assign HREADYOUT = 1'b1;   // Every access completes without wait states
    assign HRESP     = 1'b0;   // Unmapped offsets read zero, writes dropped

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_LOW_SET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (active && !s_q.ctrl[LTHM_CTRL_DIR] && q_done[0]) |=> THRESHOLD_ALARM_OUTPUT)
        else $error("low mode alarm not raised after below-low delay");
    AST_LOW_CLR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (active && !s_q.ctrl[LTHM_CTRL_DIR] && q_done[1]) |=> !THRESHOLD_ALARM_OUTPUT)
        else $error("low mode alarm not cleared after above-high delay");
    AST_HIGH_SET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (active && s_q.ctrl[LTHM_CTRL_DIR] && q_done[1]) |=> THRESHOLD_ALARM_OUTPUT)
        else $error("high mode alarm not raised after above-high delay");
    AST_HIGH_CLR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (active && s_q.ctrl[LTHM_CTRL_DIR] && q_done[0]) |=> !THRESHOLD_ALARM_OUTPUT)
        else $error("high mode alarm not cleared after below-low delay");
    AST_BADCFG_OFF: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !cfg_ok |=> !THRESHOLD_ALARM_OUTPUT)
        else $error("alarm raised with invalid thresholds");
    AST_ORDER: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (s_q.low_pct >= s_q.high_pct) |=> !THRESHOLD_ALARM_OUTPUT)
        else $error("thresholds out of order accepted");
    AST_NO_ASSIGN: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !s_q.ctrl[LTHM_CTRL_ASSIGN] |=> !THRESHOLD_ALARM_OUTPUT)
        else $error("alarm signalled without output assignment");
    AST_GATED: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (s_q.ctrl[LTHM_CTRL_EN_CFG] && !THRESHOLD_ENABLE_INPUT) |=> !THRESHOLD_ALARM_OUTPUT)
        else $error("alarm raised while enable input inactive");
    AST_STAB_LOW: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ($rose(enabled) && s_q.stab_dly != 16'h0) |-> ##1 !THRESHOLD_ALARM_OUTPUT [*2])
        else $error("alarm not held low during stabilisation");
    AST_IRQ_SET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(THRESHOLD_ALARM_OUTPUT) |-> s_q.irq_st[LTHM_IRQ_SET])
        else $error("alarm rise did not set interrupt status");

    // Zero-threshold, hold, divider and interrupt event checks
    AST_CFG_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (s_q.low_pct == LTHM_PCT_RST && s_q.high_pct == LTHM_PCT_RST) |=> !THRESHOLD_ALARM_OUTPUT)
        else $error("alarm raised with both thresholds at zero");
    AST_STAB_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        stab |=> !THRESHOLD_ALARM_OUTPUT)
        else $error("alarm raised during stabilisation");
    AST_BAND_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (active && !q_done[0] && !q_done[1]) |=> $stable(THRESHOLD_ALARM_OUTPUT))
        else $error("alarm changed inside the hysteresis band");
    AST_TICK_PULSE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_q.tick |-> (s_q.tick_cnt == 24'h0))
        else $error("seconds tick out of phase with its divider");
    AST_IRQ_CLR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $fell(THRESHOLD_ALARM_OUTPUT) |-> s_q.irq_st[LTHM_IRQ_CLR])
        else $error("alarm fall did not set interrupt status");
    AST_RD_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !(aph_valid && !HWRITE) |=> $stable(HRDATA))
        else $error("read data changed without a read");

    // ------------------------------------------------------------------
    // Cover points for the main scenarios
    // ------------------------------------------------------------------
    COV_LOW_ALARM: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        !s_q.ctrl[LTHM_CTRL_DIR] && $rose(THRESHOLD_ALARM_OUTPUT));
    COV_HIGH_ALARM: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_q.ctrl[LTHM_CTRL_DIR] && $rose(THRESHOLD_ALARM_OUTPUT));
    COV_STAB_END: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        $fell(stab) && enabled);
    COV_IRQ: cover property (@(posedge CLK_SYS) disable iff (!RST_N) $rose(IRQ));
    COV_RESTART: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        !s_q.ctrl[LTHM_CTRL_DIR] && $fell(q_cond[1]) && THRESHOLD_ALARM_OUTPUT);
endmodule : lthm_top

// file: bench/lthm_partner.sv
// Behavioural generator meter and load disconnect relay facing the monitor
`timescale 1ns/1ps
module lthm_partner (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Per-phase active power and alarm seen by the relay
    input  wire logic [15:0] ph_a,
    input  wire logic [15:0] ph_b,
    input  wire logic [15:0] ph_c,
    input  wire logic        alarm,
    // Meter output and relay state
    output logic      [15:0] power_total,
    output logic             relay_open
);
    // Meter reports only the phase sum, so a per-phase compare would misfire
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_total <= 16'h0000;
            relay_open  <= 1'b0;
        end else begin
            power_total <= ph_a + ph_b + ph_c;
            relay_open  <= alarm;
        end
    end
endmodule : lthm_partner

// file: bench/lthm_bench.sv
// Self-checking bench for the load threshold monitor with a settled-state model
`timescale 1ns/1ps
module lthm_bench
    import lthm_pkg::*;
;
    localparam int T = 10;  // Shortened second so delays stay cheap
    logic        clk, rst_n, hsel, hwrite, en_pin, alarm, irq, hreadyout, hresp, relay;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [15:0] ph_a, ph_b, ph_c, pwr;
    int          fails, samples_checked, rated, lo, hi, dir, asg, encfg, m, e, p;
    int          cyc = 0;

    lthm_top #(.PW(16), .TICK_CYCLES(T)) i_dut (
        .CLK_SYS(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .POWER_TOTAL(pwr), .THRESHOLD_ENABLE_INPUT(en_pin),
        .THRESHOLD_ALARM_OUTPUT(alarm), .IRQ(irq));
    lthm_partner i_meter (.clk(clk), .rst_n(rst_n), .ph_a(ph_a), .ph_b(ph_b), .ph_c(ph_c),
        .alarm(alarm), .power_total(pwr), .relay_open(relay));

    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    // Bounded wait for the slave's ready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            fails++;
            results();
        end
    endtask : wait_rdy

    // One single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk_bit(hresp, 1'b0, "okay response");
        hsel   <= 1'b0;
    endtask : bus

    task automatic until_cyc(input int n);
        while (cyc < n) @(posedge clk);
        @(negedge clk);
    endtask : until_cyc

    // Settled alarm level expected for a power held long enough
    function automatic int model(input int cur, input int pw);
        bit act, blw, abv;
        act = asg && !(lo == 0 && hi == 0) && lo < hi && (!encfg || en_pin);
        blw = pw * 100 < lo * rated;
        abv = pw * 100 > hi * rated;
        if (!act) return 0;
        if (dir == 0) return blw ? 1 : (abv ? 0 : cur);
        return abv ? 1 : (blw ? 0 : cur);
    endfunction : model

    // Meter sees three equal-ish phases; only their sum may count
    task automatic set_pwr(input int pw);
        @(posedge clk);
        ph_a <= 16'(pw / 3);
        ph_b <= 16'(pw / 3);
        ph_c <= 16'(pw - 2 * (pw / 3));
        p = pw;
    endtask : set_pwr

    // Hold a power level; a change must not land before d-1 s nor after d s
    task automatic step(input int pw, input int d);
        int t0;
        set_pwr(pw);
        t0 = cyc;
        e = model(m, pw);
        if (e != m) begin
            until_cyc(t0 + (d - 1) * T - 2);
            chk_bit(alarm, m[0], "alarm early");
        end
        until_cyc(t0 + d * T + 5);
        chk_bit(alarm, e[0], "alarm settled");
        chk_bit(relay, e[0], "relay follows alarm");
        m = e;
    endtask : step

    task automatic cfg(input int c, input int r, input int l, input int h, input int d);
        set_pwr(100);
        bus(1'b1, LTHM_OFS_CTRL, 32'(c));
        bus(1'b1, LTHM_OFS_RATED, 32'(r));
        bus(1'b1, LTHM_OFS_LOW_PCT, 32'(l));
        bus(1'b1, LTHM_OFS_HIGH_PCT, 32'(h));
        bus(1'b1, LTHM_OFS_LOW_DLY, 32'(d));
        bus(1'b1, LTHM_OFS_HIGH_DLY, 32'(d));
        dir = c & 1;
        asg = (c >> 1) & 1;
        encfg = (c >> 2) & 1;
        rated = r;
        lo = l;
        hi = h;
        m = model(m, 100);
        until_cyc(cyc + 3);
    endtask : cfg

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] ofs[5];
        void'($urandom(23));
        ofs = '{LTHM_OFS_CTRL, LTHM_OFS_LOW_PCT, LTHM_OFS_HIGH_PCT, LTHM_OFS_IRQ_STAT, 8'h3c};
        {rst_n, hsel, hwrite, en_pin, htrans, haddr, hwdata} = '0;
        {ph_a, ph_b, ph_c} = '0;
        {fails, samples_checked, m} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_bit(alarm, 1'b0, "reset alarm");
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            chk_word(rd, 32'h0, "reset value");
        end
        bus(1'b0, LTHM_OFS_RATED, 32'h0);
        chk_word(rd, 32'(LTHM_RATED_RST), "rated reset");
        // Inactive configurations: zero, inconsistent, unassigned
        cfg(2, 100, 0, 0, 3);
        step(10, 3);
        cfg(2, 100, 50, 50, 3);
        step(10, 3);
        bus(1'b0, LTHM_OFS_STATUS, 32'h0);
        chk_word(rd & 32'h8, 32'h8, "bad config flag");
        cfg(0, 200, 30, 60, 3);
        step(59, 3);
        // Low direction with hysteresis; only rise event unmasked
        cfg(2, 200, 30, 60, 3);
        bus(1'b1, LTHM_OFS_IRQ_MASK, 32'h1);
        step(60, 3);
        step(59, 3);
        chk_bit(irq, 1'b1, "irq on rise");
        bus(1'b0, LTHM_OFS_IRQ_STAT, 32'h0);
        chk_word(rd, 32'h1, "rise event");
        bus(1'b1, LTHM_OFS_IRQ_STAT, 32'h1);
        @(negedge clk);
        chk_bit(irq, 1'b0, "irq cleared");
        step(100, 3);
        set_pwr(121);
        until_cyc(cyc + 20);  // Two ticks at most, short of the three second delay
        step(100, 3);
        step(121, 3);
        bus(1'b0, LTHM_OFS_IRQ_STAT, 32'h0);
        chk_word(rd, 32'h2, "fall event");
        chk_bit(irq, 1'b0, "fall masked");
        bus(1'b1, LTHM_OFS_IRQ_MASK, 32'h3);
        @(negedge clk);
        chk_bit(irq, 1'b1, "fall unmasked");
        bus(1'b1, LTHM_OFS_IRQ_STAT, 32'h3);
        @(negedge clk);
        chk_bit(irq, 1'b0, "all cleared");
        // High direction
        cfg(3, 200, 30, 60, 2);
        step(121, 2);
        step(59, 2);
        // Enable input with a two second settle hold
        bus(1'b1, LTHM_OFS_STAB_DLY, 32'h2);
        cfg(6, 200, 30, 60, 3);
        step(59, 3);
        @(posedge clk);
        en_pin <= 1'b1;
        p = cyc;
        until_cyc(p + 4 * T - 2);  // Past any alarm that skipped the settle hold
        chk_bit(alarm, 1'b0, "held while settling");
        until_cyc(p + 5 * T + 6);
        chk_bit(alarm, 1'b1, "alarm after settle");
        @(posedge clk);
        en_pin <= 1'b0;
        until_cyc(cyc + 3);
        chk_bit(alarm, 1'b0, "enable dropped");
        // Random power readback of the measured total
        repeat (4) begin
            set_pwr(int'($urandom_range(0, 2000)));
            until_cyc(cyc + 3);
            bus(1'b0, LTHM_OFS_POWER, 32'h0);
            chk_word(rd, 32'(p), "power readback");
        end
        results();
    end

    // Guard against a hang
    initial begin
        #(100000 * 100);
        fails++;
        results();
    end
endmodule : lthm_bench
